/* File: core/cxs_sequencer.sv */
// CPU exception sequencer: selects the winning source, saves context and vectors.
// Assumes the core stalls while busy and supplies its live context; memory acks each access.
`timescale 1ns/1ns

// Notes on behaviour
// - Four classes: reset, address error, interrupt, instruction
// - Pending sources served strictly by fixed priority
// - Power-on on init pin rising or watchdog
// - Manual reset only from watchdog overflow
// - Errors, interrupts wait for current instruction end
// - Trap instruction execution starts trap exception
// - Undefined opcode outside slot: general illegal
// - Slot undefined or PC-modifying: slot illegal
// - Jumps, branches, returns, traps count as PC-modifying
// - Power-on fetches PC at 0, SP at 4
// - Manual fetches PC at 8, SP at 12
// - Reset clears vector base, mask all ones
// - Other exceptions push status word and PC
// - Interrupt writes its level into mask field
// - Errors and instructions keep mask unchanged
// - Fetch handler from vector table, then run
// - Illegal vectors 4 and 6; others reserved
// - Address errors 9,10; NMI 11; break 12
// - Reset fetch at vector*4, others base-relative
// - Request lines 64-67, trap vectors 32-63
module cxs_sequencer
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic external_init_pin,
  input wire logic watchdog_timer_ovf,
  input wire logic watchdog_timer_manual,
  input wire logic cpu_addr_err,
  input wire logic dma_unit_addr_err,
  input wire logic nmi_req,
  input wire logic user_break_req,
  input wire logic [3:0] irq_line,
  input wire logic [3:0] irq_level,
  input wire logic peri_req,
  input wire logic [7:0] peri_vector,
  input wire logic [3:0] peri_level,
  input wire cxs_pkg::cxs_dec_s dec,
  input wire logic insn_done,
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] cur_sp,
  input wire logic [31:0] cur_status_word,
  input wire logic [31:0] cur_vector_base,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output cxs_pkg::cxs_mem_s mem,
  output logic busy,
  output logic ctx_load,
  output cxs_pkg::cxs_ctx_s ctx,
  output cxs_pkg::cxs_src_e last_src
);
  // ****************************************************************
  // Pin synchroniser and rising-edge detect of the init pin
  // ****************************************************************
  logic [2:0] init_sync_reg;
  logic init_level_reg;
  wire init_agree = init_sync_reg[2] == init_sync_reg[1];
  wire init_rise = init_agree && init_sync_reg[1] && !init_level_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      init_sync_reg <= 3'h0;
      init_level_reg <= 1'b0;
    end
    else
    begin
      init_sync_reg <= {init_sync_reg[1:0], external_init_pin};
      if (init_agree)
        init_level_reg <= init_sync_reg[1];
    end
  end

  // ****************************************************************
  // Source decode and priority
  // ****************************************************************
  // Reset requests latch so a busy sequence cannot swallow them
  logic por_pend_reg;
  logic man_pend_reg;
  wire por_evt = init_rise || (watchdog_timer_ovf && !watchdog_timer_manual);
  wire man_evt = watchdog_timer_ovf && watchdog_timer_manual;
  wire gen_ill = dec.valid && dec.undefined && !dec.in_slot;
  wire slot_ill = dec.valid && dec.in_slot && (dec.undefined || dec.pc_modifying || dec.is_trap);
  wire trap_hit = dec.valid && dec.is_trap && !dec.in_slot;
  wire irq_any = |irq_line;
  // Lowest-numbered request line wins among the four
  wire [1:0] irq_idx = irq_line[0] ? 2'h0 : irq_line[1] ? 2'h1 : irq_line[2] ? 2'h2 : 2'h3;

  cxs_pkg::cxs_src_e sel_src;
  always_comb
  begin
    // Order of tests is the priority order
    if (por_pend_reg || por_evt)
      sel_src = cxs_pkg::CXS_SRC_POR;
    else if (man_pend_reg || man_evt)
      sel_src = cxs_pkg::CXS_SRC_MAN;
    else if (cpu_addr_err)
      sel_src = cxs_pkg::CXS_SRC_CPU_AERR;
    else if (dma_unit_addr_err)
      sel_src = cxs_pkg::CXS_SRC_DMA_AERR;
    else if (nmi_req)
      sel_src = cxs_pkg::CXS_SRC_NMI;
    else if (user_break_req)
      sel_src = cxs_pkg::CXS_SRC_UBRK;
    else if (irq_any)
      sel_src = cxs_pkg::CXS_SRC_IRQ;
    else if (peri_req)
      sel_src = cxs_pkg::CXS_SRC_PERI;
    else if (trap_hit)
      sel_src = cxs_pkg::CXS_SRC_TRAP;
    else if (gen_ill)
      sel_src = cxs_pkg::CXS_SRC_GEN_ILL;
    else if (slot_ill)
      sel_src = cxs_pkg::CXS_SRC_SLOT_ILL;
    else
      sel_src = cxs_pkg::CXS_SRC_NONE;
  end

  function automatic logic [7:0] vec_of(input cxs_pkg::cxs_src_e s, input logic [1:0] ii,
                                        input logic [7:0] pv, input logic [7:0] ti);
    unique case (s)
      cxs_pkg::CXS_SRC_POR: vec_of = cxs_pkg::VEC_POR_PC;
      cxs_pkg::CXS_SRC_MAN: vec_of = cxs_pkg::VEC_MAN_PC;
      cxs_pkg::CXS_SRC_CPU_AERR: vec_of = cxs_pkg::VEC_CPU_AERR;
      cxs_pkg::CXS_SRC_DMA_AERR: vec_of = cxs_pkg::VEC_DMA_AERR;
      cxs_pkg::CXS_SRC_NMI: vec_of = cxs_pkg::VEC_NMI;
      cxs_pkg::CXS_SRC_UBRK: vec_of = cxs_pkg::VEC_UBRK;
      cxs_pkg::CXS_SRC_IRQ: vec_of = cxs_pkg::VEC_IRQ0 + {6'h00, ii};
      cxs_pkg::CXS_SRC_PERI: vec_of = pv;
      // Out-of-range trap numbers are forced into the user window
      cxs_pkg::CXS_SRC_TRAP: vec_of = cxs_pkg::VEC_TRAP_LO | (ti & 8'h1F);
      cxs_pkg::CXS_SRC_GEN_ILL: vec_of = cxs_pkg::VEC_GEN_ILL;
      cxs_pkg::CXS_SRC_SLOT_ILL: vec_of = cxs_pkg::VEC_SLOT_ILL;
      default: vec_of = cxs_pkg::VEC_GEN_ILL;
    endcase
  endfunction

  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
    vec_addr = base + {22'h000000, v, 2'h0};
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    CXS_IDLE = 3'h0,
    CXS_RST_PC = 3'h1,
    CXS_RST_SP = 3'h2,
    CXS_PUSH_SW = 3'h3,
    CXS_PUSH_PC = 3'h4,
    CXS_FETCH = 3'h5,
    CXS_LOAD = 3'h6
  } cxs_state_e;

  cxs_state_e state_reg;
  cxs_state_e state_next;
  logic [7:0] vec_reg;
  logic is_man_reg;
  logic [31:0] pc_reg;
  logic [31:0] sp_reg;
  logic [31:0] vb_reg;
  logic [31:0] sw_reg;
  logic [31:0] save_pc_reg;
  logic [31:0] save_sw_reg;

  wire is_reset = (sel_src == cxs_pkg::CXS_SRC_POR) || (sel_src == cxs_pkg::CXS_SRC_MAN);
  // Resets start as soon as the sequencer is idle; the rest also wait for the running instruction to finish
  wire start = (state_reg == CXS_IDLE) && (sel_src != cxs_pkg::CXS_SRC_NONE) &&
               (is_reset || insn_done);
  wire por_take = start && (sel_src == cxs_pkg::CXS_SRC_POR);
  wire man_take = start && (sel_src == cxs_pkg::CXS_SRC_MAN);
  wire is_irq = (sel_src >= cxs_pkg::CXS_SRC_NMI) && (sel_src <= cxs_pkg::CXS_SRC_PERI);
  wire [3:0] new_level = (sel_src == cxs_pkg::CXS_SRC_NMI) ? cxs_pkg::NMI_LEVEL :
                         (sel_src == cxs_pkg::CXS_SRC_UBRK) ? cxs_pkg::UBRK_LEVEL :
                         (sel_src == cxs_pkg::CXS_SRC_IRQ) ? irq_level : peri_level;
  wire [31:0] sw_irq = (cur_status_word & ~(32'h0000_000F << cxs_pkg::IMASK_LSB)) |
                       ({28'h0000000, new_level} << cxs_pkg::IMASK_LSB);
  wire [31:0] sw_rst = sw_reg | ({28'h0000000, cxs_pkg::IMASK_RST} << cxs_pkg::IMASK_LSB);
  wire rst_dual = state_reg == CXS_RST_PC;
  wire [7:0] rst_sp_vec = is_man_reg ? cxs_pkg::VEC_MAN_SP : cxs_pkg::VEC_POR_SP;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CXS_IDLE: if (start) state_next = is_reset ? CXS_RST_PC : CXS_PUSH_SW;
      CXS_RST_PC: if (mem_ack) state_next = CXS_RST_SP;
      CXS_RST_SP: if (mem_ack) state_next = CXS_LOAD;
      CXS_PUSH_SW: if (mem_ack) state_next = CXS_PUSH_PC;
      CXS_PUSH_PC: if (mem_ack) state_next = CXS_FETCH;
      CXS_FETCH: if (mem_ack) state_next = CXS_LOAD;
      CXS_LOAD: state_next = CXS_IDLE;
      default: state_next = CXS_IDLE;
    endcase
  end

  // Memory request for the current step, registered one cycle ahead
  cxs_pkg::cxs_mem_s mem_next;
  always_comb
  begin
    mem_next = '0;
    unique case (state_next)
      CXS_RST_PC:
      begin
        mem_next.req = 1'b1;
        mem_next.addr = {22'h000000, vec_reg, 2'h0};
      end
      CXS_RST_SP:
      begin
        mem_next.req = 1'b1;
        mem_next.addr = {22'h000000, rst_sp_vec, 2'h0};
      end
      CXS_PUSH_SW:
      begin
        mem_next.req = 1'b1;
        mem_next.wr = 1'b1;
        mem_next.addr = sp_reg - cxs_pkg::STACK_STEP;
        mem_next.wdata = save_sw_reg;
      end
      CXS_PUSH_PC:
      begin
        mem_next.req = 1'b1;
        mem_next.wr = 1'b1;
        mem_next.addr = sp_reg - cxs_pkg::STACK_STEP;
        mem_next.wdata = save_pc_reg;
      end
      CXS_FETCH:
      begin
        mem_next.req = 1'b1;
        mem_next.addr = vec_addr(vb_reg, vec_reg);
      end
      default: mem_next = '0;
    endcase
    // Entry cycle: the saved-context registers load in the same edge, so source them directly
    if (state_reg == CXS_IDLE && state_next == CXS_PUSH_SW)
    begin
      mem_next.addr = cur_sp - cxs_pkg::STACK_STEP;
      mem_next.wdata = is_irq ? cur_status_word : cur_status_word;
    end
    if (state_reg == CXS_IDLE && state_next == CXS_RST_PC)
      mem_next.addr = {22'h000000, vec_of(sel_src, irq_idx, peri_vector, dec.trap_imm), 2'h0};
    if (mem_ack && state_next != state_reg)
    begin
      if (state_next == CXS_PUSH_PC)
        mem_next.addr = sp_reg - (cxs_pkg::STACK_STEP << 1);
      if (rst_dual)
        mem_next.addr = {22'h000000, rst_sp_vec, 2'h0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= CXS_IDLE;
      por_pend_reg <= 1'b0;
      man_pend_reg <= 1'b0;
      vec_reg <= 8'h00;
      is_man_reg <= 1'b0;
      pc_reg <= 32'h0000_0000;
      sp_reg <= 32'h0000_0000;
      vb_reg <= 32'h0000_0000;
      sw_reg <= 32'h0000_0000;
      save_pc_reg <= 32'h0000_0000;
      save_sw_reg <= 32'h0000_0000;
      mem <= '0;
      busy <= 1'b0;
      ctx_load <= 1'b0;
      ctx <= '0;
      last_src <= cxs_pkg::CXS_SRC_NONE;
    end
    else
    begin
      state_reg <= state_next;
      mem <= mem_next;
      busy <= state_next != CXS_IDLE;
      ctx_load <= state_reg == CXS_LOAD;
      // New reset events win over the clear, unless that very event is the one starting now
      por_pend_reg <= (por_evt && !(por_take && !por_pend_reg)) || (por_pend_reg && !por_take);
      man_pend_reg <= (man_evt && !(man_take && !man_pend_reg)) || (man_pend_reg && !man_take);
      if (start)
      begin
        last_src <= sel_src;
        vec_reg <= vec_of(sel_src, irq_idx, peri_vector, dec.trap_imm);
        is_man_reg <= sel_src == cxs_pkg::CXS_SRC_MAN;
        save_pc_reg <= cur_pc;
        save_sw_reg <= cur_status_word;
        sp_reg <= cur_sp;
        pc_reg <= cur_pc;
        vb_reg <= is_reset ? cxs_pkg::VECTOR_BASE_RST : cur_vector_base;
        // Mask untouched for errors and instructions
        sw_reg <= is_irq ? sw_irq : cur_status_word;
      end
      if (mem_ack)
      begin
        unique case (state_reg)
          CXS_RST_PC: pc_reg <= mem_rdata;
          CXS_RST_SP:
          begin
            sp_reg <= mem_rdata;
            sw_reg <= sw_rst;
          end
          CXS_PUSH_SW, CXS_PUSH_PC: sp_reg <= sp_reg - cxs_pkg::STACK_STEP;
          CXS_FETCH: pc_reg <= mem_rdata;
          default: pc_reg <= pc_reg;
        endcase
      end
      if (state_reg == CXS_LOAD)
      begin
        ctx.pc <= pc_reg;
        ctx.sp <= sp_reg;
        ctx.vector_base <= vb_reg;
        ctx.status_word <= sw_reg;
      end
    end
  end
endmodule

/* File: include/cxs_pkg.sv */
// Package for the CPU exception sequencer: vectors, fetch offsets, priorities and carriers.
// Assumes a 32-bit memory port with one-cycle-or-longer request/ack handshake.
package cxs_pkg;
  // ****************************************************************
  // Vector numbers and fixed reset offsets
  // ****************************************************************
  localparam logic [7:0] VEC_POR_PC = 8'h00;
  localparam logic [7:0] VEC_POR_SP = 8'h01;
  localparam logic [7:0] VEC_MAN_PC = 8'h02;
  localparam logic [7:0] VEC_MAN_SP = 8'h03;
  localparam logic [7:0] VEC_GEN_ILL = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
  localparam logic [7:0] VEC_CPU_AERR = 8'h09;
  localparam logic [7:0] VEC_DMA_AERR = 8'h0A;
  localparam logic [7:0] VEC_NMI = 8'h0B;
  localparam logic [7:0] VEC_UBRK = 8'h0C;
  localparam logic [7:0] VEC_TRAP_LO = 8'h20;
  localparam logic [7:0] VEC_TRAP_HI = 8'h3F;
  localparam logic [7:0] VEC_IRQ0 = 8'h40;
  localparam logic [31:0] VECTOR_BASE_RST = 32'h0000_0000;
  localparam logic [3:0] IMASK_RST = 4'hF;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam int IMASK_LSB = 4;
  localparam logic [3:0] NMI_LEVEL = 4'hF;
  localparam logic [3:0] UBRK_LEVEL = 4'hF;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    CXS_SRC_NONE = 4'h0,
    CXS_SRC_POR = 4'h1,
    CXS_SRC_MAN = 4'h2,
    CXS_SRC_CPU_AERR = 4'h3,
    CXS_SRC_DMA_AERR = 4'h4,
    CXS_SRC_NMI = 4'h5,
    CXS_SRC_UBRK = 4'h6,
    CXS_SRC_IRQ = 4'h7,
    CXS_SRC_PERI = 4'h8,
    CXS_SRC_TRAP = 4'h9,
    CXS_SRC_GEN_ILL = 4'hA,
    CXS_SRC_SLOT_ILL = 4'hB
  } cxs_src_e;

  // Decoded instruction facts from the pipeline
  typedef struct packed {
    logic valid;
    logic undefined;
    logic in_slot;
    logic pc_modifying;
    logic is_trap;
    logic [7:0] trap_imm;
  } cxs_dec_s;

  // Memory request toward the bus
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cxs_mem_s;

  // Final state handed back to the core
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] vector_base;
    logic [31:0] status_word;
  } cxs_ctx_s;
endpackage

/* File: verif/cxs_mem_model.sv */
// Memory partner: vector table and stack, acking after random waits.
// Assumes the requester holds its access until acked; bench sets the seed.
`timescale 1ns/1ns
module cxs_mem_model
#(
  parameter logic [31:0] KEY = 32'h0000_0000
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire cxs_pkg::cxs_mem_s mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  int wait_cnt;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'hFFFF_FFFF;
      wait_cnt <= 0;
    end
    else if (mem.req && !mem_ack && wait_cnt == 0)
    begin
      // Distinct word per address so a wrong fetch shows
      mem_ack <= 1'b1;
      mem_rdata <= mem.addr ^ KEY;
      wait_cnt <= $urandom_range(3, 0);
    end
    else
    begin
      mem_ack <= 1'b0;
      // Released bus must not keep its last value
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack)
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

/* File: verif/cxs_sequencer_bench.sv */
// Bench: resets, priority, interrupt lines, instruction faults.
// Assumes the memory model and the checker bound at the foot.
`timescale 1ns/1ns
module cxs_sequencer_bench;
  typedef struct packed {cxs_pkg::cxs_src_e src; logic [31:0] pc;
    logic [31:0] sp; logic [31:0] vb; logic [3:0] mask;} cxs_exp_s;
  localparam logic [31:0] KEY = 32'h5AC3_0000;
  logic mclk, arst_n, pin, ovf, man, cerr, derr, nmi, ubrk, peri, done, ack, busy, ctx_load;
  logic [3:0] irq, ilvl, plvl;
  logic [7:0] pvec, imm;
  logic [31:0] pc, sp, sw, vb, rdata;
  cxs_pkg::cxs_dec_s dec;
  cxs_pkg::cxs_mem_s mem;
  cxs_pkg::cxs_ctx_s ctx;
  cxs_pkg::cxs_src_e last_src;
  int failures, tests_run;
  cxs_exp_s q[$];
  cxs_exp_s e;
  cxs_sequencer dut (.mclk(mclk), .arst_n(arst_n), .external_init_pin(pin), .watchdog_timer_ovf(ovf),
    .watchdog_timer_manual(man), .cpu_addr_err(cerr), .dma_unit_addr_err(derr), .nmi_req(nmi),
    .user_break_req(ubrk), .irq_line(irq), .irq_level(ilvl), .peri_req(peri), .peri_vector(pvec),
    .peri_level(plvl), .dec(dec), .insn_done(done), .cur_pc(pc), .cur_sp(sp), .cur_status_word(sw),
    .cur_vector_base(vb), .mem_ack(ack), .mem_rdata(rdata), .mem(mem), .busy(busy),
    .ctx_load(ctx_load), .ctx(ctx), .last_src(last_src));
  cxs_mem_model #(.KEY(KEY)) mem_model (.mclk(mclk), .arst_n(arst_n), .mem(mem), .mem_ack(ack),
    .mem_rdata(rdata));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****
  // Tasks
  // ****
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_val(string n, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cmp_src(cxs_pkg::cxs_src_e x, cxs_pkg::cxs_src_e g);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("ERROR last_src expected %0d seen %0d", x, g);
    end
  endtask
  task automatic note(cxs_pkg::cxs_src_e s, logic [7:0] v, logic [3:0] l, logic i);
    cxs_exp_s x;
    logic r;
    logic [31:0] o;
    r = s == cxs_pkg::CXS_SRC_POR || s == cxs_pkg::CXS_SRC_MAN;
    o = {22'h0, v, 2'h0};
    x.src = s;
    x.pc = (r ? o : vb + o) ^ KEY;
    x.sp = r ? (o + 32'h4) ^ KEY : sp - 32'h8;
    x.vb = r ? 32'h0 : vb;
    x.mask = r ? 4'hF : (i ? l : sw[7:4]);
    q.push_back(x);
  endtask
  task automatic wait_for(logic b);
    int n;
    n = 0;
    while ((b ? busy : ctx_load) !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 300)
      begin
        failures++;
        $display("ERROR wait for sequencer ran out");
        tally_and_finish();
      end
    end
  endtask
  task automatic serve(cxs_pkg::cxs_src_e s);
    wait_for(1'b1);
    case (s)
      cxs_pkg::CXS_SRC_CPU_AERR: cerr = 1'b0;
      cxs_pkg::CXS_SRC_DMA_AERR: derr = 1'b0;
      cxs_pkg::CXS_SRC_NMI: nmi = 1'b0;
      cxs_pkg::CXS_SRC_UBRK: ubrk = 1'b0;
      cxs_pkg::CXS_SRC_IRQ: irq = 4'h0;
      cxs_pkg::CXS_SRC_PERI: peri = 1'b0;
      default: dec = '0;
    endcase
    wait_for(1'b0);
    @(posedge mclk);
    #1;
  endtask
  task automatic quiet(int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      cmp_val("busy", 32'h0, {31'h0, busy});
    end
  endtask
  task automatic wdt(logic m);
    note(m ? cxs_pkg::CXS_SRC_MAN : cxs_pkg::CXS_SRC_POR, m ? 8'h02 : 8'h00, 4'h0, 1'b0);
    {ovf, man} = {1'b1, m};
    @(posedge mclk);
    #1;
    ovf = 1'b0;
    serve(cxs_pkg::CXS_SRC_POR);
  endtask
  // Watcher pairs each context load with the oldest note
  always @(negedge mclk)
  begin
    if (arst_n && ctx_load === 1'b1)
    begin
      e = q.pop_front();
      cmp_src(e.src, last_src);
      cmp_val("pc", e.pc, ctx.pc);
      cmp_val("sp", e.sp, ctx.sp);
      cmp_val("base", e.vb, ctx.vector_base);
      cmp_val("mask", {28'h0, e.mask}, {28'h0, ctx.status_word[7:4]});
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    {arst_n, pin, ovf, man, cerr, derr, nmi, ubrk, peri, irq, dec, done} = '0;
    {ilvl, plvl, pvec, pc, sp, sw, vb} = '0;
    void'($urandom(28732));
    repeat (12) @(posedge mclk);
    #1;
    {arst_n, done} = 2'h3;
    pc = $urandom;
    sp = $urandom & 32'hFFFF_FFFC;
    sw = $urandom;
    vb = $urandom & 32'h00FF_FFFC;
    note(cxs_pkg::CXS_SRC_POR, 8'h00, 4'h0, 1'b0);
    pin = 1'b1;
    serve(cxs_pkg::CXS_SRC_POR);
    wdt(1'b0);
    wdt(1'b1);
    done = 1'b0;
    nmi = 1'b1;
    quiet(10);
    done = 1'b1;
    note(cxs_pkg::CXS_SRC_NMI, 8'h0B, 4'hF, 1'b1);
    note(cxs_pkg::CXS_SRC_MAN, 8'h02, 4'h0, 1'b0);
    wait_for(1'b1);
    // Watchdog fires mid-sequence: the reset must wait, then run exactly once
    {ovf, man} = 2'h3;
    @(posedge mclk);
    #1;
    ovf = 1'b0;
    serve(cxs_pkg::CXS_SRC_NMI);
    serve(cxs_pkg::CXS_SRC_MAN);
    ilvl = 4'($urandom);
    plvl = 4'($urandom);
    pvec = 8'(72 + $urandom % 184);
    {cerr, derr, ubrk, peri, irq} = 8'hF4;
    note(cxs_pkg::CXS_SRC_CPU_AERR, 8'h09, 4'h0, 1'b0);
    note(cxs_pkg::CXS_SRC_DMA_AERR, 8'h0A, 4'h0, 1'b0);
    note(cxs_pkg::CXS_SRC_UBRK, 8'h0C, 4'hF, 1'b1);
    note(cxs_pkg::CXS_SRC_IRQ, 8'h42, ilvl, 1'b1);
    note(cxs_pkg::CXS_SRC_PERI, pvec, plvl, 1'b1);
    for (int k = 0; k < 5; k++)
      serve(q[0].src);
    for (int k = 0; k < 4; k++)
    begin
      ilvl = 4'($urandom);
      irq = 4'h1 << k;
      note(cxs_pkg::CXS_SRC_IRQ, 8'(64 + k), ilvl, 1'b1);
      serve(cxs_pkg::CXS_SRC_IRQ);
    end
    for (int k = 0; k < 6; k++)
    begin
      imm = 8'($urandom);
      case (k)
        0: dec = {5'h11, imm};
        1: dec = {5'h18, 8'h00};
        2: dec = {5'h1C, 8'h00};
        3: dec = {5'h16, 8'h00};
        4: dec = {5'h17, imm};
        default: dec = {5'h12, 8'h00};
      endcase
      if (k == 0)
        note(cxs_pkg::CXS_SRC_TRAP, 8'h20 | {3'h0, imm[4:0]}, 4'h0, 1'b0);
      else if (k == 1)
        note(cxs_pkg::CXS_SRC_GEN_ILL, 8'h04, 4'h0, 1'b0);
      else if (k < 5)
        note(cxs_pkg::CXS_SRC_SLOT_ILL, 8'h06, 4'h0, 1'b0);
      if (k < 5)
        serve(cxs_pkg::CXS_SRC_TRAP);
      else
        quiet(8);
    end
    dec = '0;
    cmp_val("notes left", 32'h0, q.size());
    tally_and_finish();
  end
endmodule
bind cxs_sequencer cxs_sequencer_chk chk (.mclk(mclk), .arst_n(arst_n), .insn_done(insn_done),
  .cur_pc(cur_pc), .cur_sp(cur_sp), .cur_status_word(cur_status_word), .mem_ack(mem_ack), .mem(mem),
  .busy(busy), .ctx_load(ctx_load), .ctx(ctx), .last_src(last_src));

/* File: verif/cxs_sequencer_chk_sva.sv */
// Checker: bus hold, push order, fetch addresses and mask results.
// Assumes core context inputs stay steady while a sequence runs.
`timescale 1ns/1ns
module cxs_sequencer_chk
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic insn_done,
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] cur_sp,
  input wire logic [31:0] cur_status_word,
  input wire logic mem_ack,
  input wire cxs_pkg::cxs_mem_s mem,
  input wire logic busy,
  input wire logic ctx_load,
  input wire cxs_pkg::cxs_ctx_s ctx,
  input wire cxs_pkg::cxs_src_e last_src
);
  wire logic por = last_src == cxs_pkg::CXS_SRC_POR;
  wire logic man = last_src == cxs_pkg::CXS_SRC_MAN;
  wire logic rst = por || man;
  wire logic lvl_f = last_src == cxs_pkg::CXS_SRC_NMI || last_src == cxs_pkg::CXS_SRC_UBRK;
  wire logic intr = lvl_f || last_src == cxs_pkg::CXS_SRC_IRQ || last_src == cxs_pkg::CXS_SRC_PERI;
  wire logic [3:0] mask = ctx.status_word[7:4];
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ****
  // Steps
  // ****
  sequence seq_start;
    $rose(busy);
  endsequence
  sequence seq_push_sw;
    mem.req && mem.wr && mem.addr == cur_sp - 32'h4 && mem.wdata == cur_status_word;
  endsequence
  sequence seq_read(logic [31:0] a);
    mem.req && !mem.wr && mem.addr == a;
  endsequence
  // ****
  // Rules
  // ****
  chk_req_held: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
    else $error("Request changed before ack");
  chk_por_fetch: assert property (seq_start ##0 por |-> ##[0:1] seq_read(32'h0))
    else $error("Power-on fetch address wrong");
  chk_man_fetch: assert property (seq_start ##0 man |-> ##[0:1] seq_read(32'h8))
    else $error("Manual fetch address wrong");
  chk_push_order: assert property (seq_start ##0 !rst |-> ##[0:1] seq_push_sw)
    else $error("Status word not pushed first");
  chk_pc_push: assert property (seq_push_sw ##0 mem_ack |=>
    mem.req && mem.wr && mem.addr == cur_sp - 32'h8 && mem.wdata == cur_pc)
    else $error("PC push wrong");
  chk_reset_ctx: assert property (ctx_load && rst |-> ctx.vector_base == 32'h0 && mask == 4'hF)
    else $error("Reset context wrong");
  chk_level_top: assert property (ctx_load && lvl_f |-> mask == 4'hF)
    else $error("Top level mask wrong");
  chk_mask_kept: assert property (ctx_load && !rst && !intr |-> mask == cur_status_word[7:4])
    else $error("Mask changed");
  chk_insn_wait: assert property (seq_start ##0 !rst |-> $past(insn_done))
    else $error("Started before instruction end");
  chk_stack_sp: assert property (ctx_load && !rst |-> ctx.sp == cur_sp - 32'h8)
    else $error("Stack pointer wrong");
endmodule
